// file: hw/rcr_config_regs.sv
// Configuration register bank of a multi-lane repeater, lane B0 controls.
// Assumes an SMBus byte engine on ref_clk_in delivers one-cycle read and write strobes.
//
// Overview of operation
// - Soft reset bit restores all register defaults.
// - Each power-down bit disables one channel.
// - Bits 7:4 side A, 3:0 side B.
// - Override bit decides power-down pin control.
// - Override bit 4 blocks the idle pin.
// - Override bit 2 blocks the rate pin.
// - Auto idle bit else forced idle select.
// - Forced idle: zero active, one muted.
// - Auto rate bit else forced rate select.
// - Boost field: enable, gain stage, level.
// - Boost field resets to bypass code.
// - Swing field resets to 600 mV code.
// - Write is address, register, data byte.
`timescale 1ns/100ps
`include "rcr_defs.svh"

module rcr_config_regs (
  input  wire logic                  ref_clk_in,
  input  wire logic                  resetn_in,
  input  wire logic                  serial_config_enable_in,
  input  wire logic                  power_down_pin_in,
  input  wire logic                  idle_pin_in,
  input  wire logic                  rate_pin_in,
  input  wire logic                  wr_strobe_in,
  input  wire logic                  rd_strobe_in,
  input  wire logic [7:0]            reg_addr_in,
  input  wire logic [7:0]            wr_data_in,
  output logic      [7:0]            rd_data_out,
  output logic      [7:0]            lane_power_down_out,
  output rcr_pkg::rcr_lane_ctl_s     b0_lane_ctl_out,
  output rcr_pkg::rcr_boost_s        b0_receive_boost_out,
  output logic      [5:0]            b0_output_swing_out
);

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  localparam int NPIN = 4;

  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] sync1_r, sync2_r, sync3_r, pin_r;
  logic [NPIN-1:0] pin_nxt;

  assign pin_raw = {rate_pin_in, idle_pin_in, power_down_pin_in, serial_config_enable_in};

  // A pin change is accepted only once the second and third stages agree.
  always_comb begin
    for (int i = 0; i < NPIN; i++) begin
      pin_nxt[i] = (sync2_r[i] == sync3_r[i]) ? sync3_r[i] : pin_r[i];
    end
  end

  // Three-stage chain plus the settled level.
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sync1_r <= '0;
      sync2_r <= '0;
      sync3_r <= '0;
      pin_r   <= '0;
    end else begin
      sync1_r <= pin_raw;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      pin_r   <= pin_nxt;
    end
  end

  logic enable_ok, pd_pin, idle_pin, rate_pin;
  assign enable_ok = pin_r[0];
  assign pd_pin    = pin_r[1];
  assign idle_pin  = pin_r[2];
  assign rate_pin  = pin_r[3];

  // --------------------------------------------------------------------------
  // Register file
  // --------------------------------------------------------------------------
  logic [7:0]          power_down_r,  power_down_nxt;
  logic                pd_override_r, pd_override_nxt;
  logic                ovr_idle_r,    ovr_idle_nxt;
  logic                ovr_rate_r,    ovr_rate_nxt;
  logic                idle_auto_r,   idle_auto_nxt;
  logic                idle_sel_r,    idle_sel_nxt;
  logic                rate_auto_r,   rate_auto_nxt;
  logic                rate_sel_r,    rate_sel_nxt;
  rcr_pkg::rcr_boost_s boost_r,       boost_nxt;
  logic [5:0]          swing_r,       swing_nxt;
  logic [7:0]          rdata_r,       rdata_nxt;
  logic                wr_ok, rd_ok;

  assign wr_ok = wr_strobe_in && enable_ok;
  assign rd_ok = rd_strobe_in && enable_ok;

  // Next register values from bus writes and soft reset.
  always_comb begin
    power_down_nxt  = power_down_r;
    pd_override_nxt = pd_override_r;
    ovr_idle_nxt    = ovr_idle_r;
    ovr_rate_nxt    = ovr_rate_r;
    idle_auto_nxt   = idle_auto_r;
    idle_sel_nxt    = idle_sel_r;
    rate_auto_nxt   = rate_auto_r;
    rate_sel_nxt    = rate_sel_r;
    boost_nxt       = boost_r;
    swing_nxt       = swing_r;
    if (wr_ok) begin
      if (reg_addr_in == `RCR_OFS_SOFT_RESET) begin
        if (wr_data_in[`RCR_BIT_SOFT_RESET]) begin
          power_down_nxt  = `RCR_RST_POWER_DOWN;
          pd_override_nxt = `RCR_RST_PD_OVERRIDE;
          ovr_idle_nxt    = `RCR_RST_PIN_OVERRIDE;
          ovr_rate_nxt    = `RCR_RST_PIN_OVERRIDE;
          idle_auto_nxt   = `RCR_RST_IDLE_RATE;
          idle_sel_nxt    = `RCR_RST_IDLE_RATE;
          rate_auto_nxt   = `RCR_RST_IDLE_RATE;
          rate_sel_nxt    = `RCR_RST_IDLE_RATE;
          boost_nxt       = `RCR_RST_BOOST;
          swing_nxt       = `RCR_RST_SWING;
        end
      end else if (reg_addr_in == `RCR_OFS_POWER_DOWN) begin
        power_down_nxt = wr_data_in;
      end else if (reg_addr_in == `RCR_OFS_PD_OVERRIDE) begin
        pd_override_nxt = wr_data_in[`RCR_BIT_PD_OVERRIDE];
      end else if (reg_addr_in == `RCR_OFS_PIN_OVERRIDE) begin
        ovr_idle_nxt = wr_data_in[`RCR_BIT_OVR_IDLE];
        ovr_rate_nxt = wr_data_in[`RCR_BIT_OVR_RATE];
      end else if (reg_addr_in == `RCR_OFS_B0_IDLE_RATE) begin
        idle_auto_nxt = wr_data_in[`RCR_BIT_IDLE_AUTO];
        idle_sel_nxt  = wr_data_in[`RCR_BIT_IDLE_SEL];
        rate_auto_nxt = wr_data_in[`RCR_BIT_RATE_AUTO];
        rate_sel_nxt  = wr_data_in[`RCR_BIT_RATE_SEL];
      end else if (reg_addr_in == `RCR_OFS_B0_BOOST) begin
        boost_nxt = wr_data_in[5:0];
      end else if (reg_addr_in == `RCR_OFS_B0_SWING) begin
        swing_nxt = wr_data_in[5:0];
      end
    end
  end

  // Read data mux; unmapped offsets and reserved bits return zero.
  always_comb begin
    rdata_nxt = rdata_r;
    if (rd_ok) begin
      rdata_nxt = 8'h00;
      if (reg_addr_in == `RCR_OFS_POWER_DOWN) begin
        rdata_nxt = power_down_r;
      end else if (reg_addr_in == `RCR_OFS_PD_OVERRIDE) begin
        rdata_nxt[`RCR_BIT_PD_OVERRIDE] = pd_override_r;
      end else if (reg_addr_in == `RCR_OFS_PIN_OVERRIDE) begin
        rdata_nxt[`RCR_BIT_OVR_IDLE] = ovr_idle_r;
        rdata_nxt[`RCR_BIT_OVR_RATE] = ovr_rate_r;
      end else if (reg_addr_in == `RCR_OFS_B0_IDLE_RATE) begin
        rdata_nxt[`RCR_BIT_IDLE_AUTO] = idle_auto_r;
        rdata_nxt[`RCR_BIT_IDLE_SEL]  = idle_sel_r;
        rdata_nxt[`RCR_BIT_RATE_AUTO] = rate_auto_r;
        rdata_nxt[`RCR_BIT_RATE_SEL]  = rate_sel_r;
      end else if (reg_addr_in == `RCR_OFS_B0_BOOST) begin
        rdata_nxt = {2'h0, boost_r};
      end else if (reg_addr_in == `RCR_OFS_B0_SWING) begin
        rdata_nxt = {2'h0, swing_r};
      end
    end
  end

  // Register storage.
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      power_down_r  <= `RCR_RST_POWER_DOWN;
      pd_override_r <= `RCR_RST_PD_OVERRIDE;
      ovr_idle_r    <= `RCR_RST_PIN_OVERRIDE;
      ovr_rate_r    <= `RCR_RST_PIN_OVERRIDE;
      idle_auto_r   <= `RCR_RST_IDLE_RATE;
      idle_sel_r    <= `RCR_RST_IDLE_RATE;
      rate_auto_r   <= `RCR_RST_IDLE_RATE;
      rate_sel_r    <= `RCR_RST_IDLE_RATE;
      boost_r       <= `RCR_RST_BOOST;
      swing_r       <= `RCR_RST_SWING;
      rdata_r       <= `RCR_RST_RDATA;
    end else begin
      power_down_r  <= power_down_nxt;
      pd_override_r <= pd_override_nxt;
      ovr_idle_r    <= ovr_idle_nxt;
      ovr_rate_r    <= ovr_rate_nxt;
      idle_auto_r   <= idle_auto_nxt;
      idle_sel_r    <= idle_sel_nxt;
      rate_auto_r   <= rate_auto_nxt;
      rate_sel_r    <= rate_sel_nxt;
      boost_r       <= boost_nxt;
      swing_r       <= swing_nxt;
      rdata_r       <= rdata_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // Effective lane controls
  // --------------------------------------------------------------------------
  logic [7:0]             lane_pd_r, lane_pd_nxt;
  rcr_pkg::rcr_lane_ctl_s ctl_r,     ctl_nxt;

  // Combine register settings with the pins that are not blocked.
  always_comb begin
    lane_pd_nxt = power_down_r | {8{pd_pin && !pd_override_r}};
    if (!ovr_idle_r) begin
      ctl_nxt.auto_idle   = idle_pin;
      ctl_nxt.output_mute = 1'b0;
    end else begin
      ctl_nxt.auto_idle   = idle_auto_r;
      ctl_nxt.output_mute = !idle_auto_r && idle_sel_r;
    end
    if (!ovr_rate_r) begin
      ctl_nxt.auto_rate = 1'b0;
      ctl_nxt.rate_high = rate_pin;
    end else begin
      ctl_nxt.auto_rate = rate_auto_r;
      ctl_nxt.rate_high = !rate_auto_r && rate_sel_r;
    end
  end

  // Output flops.
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      lane_pd_r <= '0;
      ctl_r     <= '0;
    end else begin
      lane_pd_r <= lane_pd_nxt;
      ctl_r     <= ctl_nxt;
    end
  end

  assign rd_data_out          = rdata_r;
  assign lane_power_down_out  = lane_pd_r;
  assign b0_lane_ctl_out      = ctl_r;
  assign b0_receive_boost_out = boost_r;
  assign b0_output_swing_out  = swing_r;

endmodule

// file: hw/rcr_defs.svh
// Register offsets, field positions, reset values and sync depth for the repeater config bank.
// Included by the top module; holds definitions only.
`ifndef RCR_DEFS_SVH
`define RCR_DEFS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define RCR_OFS_SOFT_RESET    8'h00
`define RCR_OFS_POWER_DOWN    8'h01
`define RCR_OFS_PD_OVERRIDE   8'h02
`define RCR_OFS_PIN_OVERRIDE  8'h08
`define RCR_OFS_B0_IDLE_RATE  8'h0e
`define RCR_OFS_B0_BOOST      8'h0f
`define RCR_OFS_B0_SWING      8'h10

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define RCR_BIT_SOFT_RESET    0
`define RCR_BIT_PD_OVERRIDE   0
`define RCR_BIT_OVR_IDLE      4
`define RCR_BIT_OVR_RATE      2
`define RCR_BIT_IDLE_AUTO     5
`define RCR_BIT_IDLE_SEL      4
`define RCR_BIT_RATE_AUTO     1
`define RCR_BIT_RATE_SEL      0

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RCR_RST_POWER_DOWN    8'h00
`define RCR_RST_PD_OVERRIDE   1'b0
`define RCR_RST_PIN_OVERRIDE  1'b0
`define RCR_RST_IDLE_RATE     1'b0
`define RCR_RST_BOOST         6'h20
`define RCR_RST_SWING         6'h03
`define RCR_RST_RDATA         8'h00

// ----------------------------------------------------------------------------
// Pin synchroniser depth
// ----------------------------------------------------------------------------
`define RCR_SYNC_STAGES       3

`endif

// file: hw/rcr_pkg.sv
// Types shared by the repeater configuration bank and its users.
// Assumes the defs header is on the include path.
package rcr_pkg;

  // --------------------------------------------------------------------------
  // Receive boost field: enable, gain stage, boost level.
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic       enable;
    logic [1:0] gain_stage_select;
    logic [2:0] boost_level_select;
  } rcr_boost_s;

  // Effective lane-B0 idle and rate controls.
  typedef struct packed {
    logic auto_idle;
    logic output_mute;
    logic auto_rate;
    logic rate_high;
  } rcr_lane_ctl_s;

endpackage

// file: dv/rcr_config_regs_properties.sv
// Port checker for the repeater configuration bank.
// Assumes it is bound to rcr_config_regs and that all strobes run on ref_clk_in.
`timescale 1ns/100ps
module rcr_config_regs_chk (
  input wire logic                   ref_clk_in,
  input wire logic                   resetn_in,
  input wire logic                   serial_config_enable_in,
  input wire logic                   wr_strobe_in,
  input wire logic                   rd_strobe_in,
  input wire logic [7:0]             reg_addr_in,
  input wire logic [7:0]             wr_data_in,
  input wire logic [7:0]             rd_data_out,
  input wire logic [7:0]             lane_power_down_out,
  input wire rcr_pkg::rcr_lane_ctl_s b0_lane_ctl_out,
  input wire rcr_pkg::rcr_boost_s    b0_receive_boost_out,
  input wire logic [5:0]             b0_output_swing_out
);
  logic [2:0] en_cnt_r;
  logic [2:0] en_cnt_nxt;
  logic       en_ok;

  // Counts edges with the enable pin high; the bank is trusted once it is settled.
  always_comb begin
    en_cnt_nxt = (en_cnt_r == 3'h7) ? en_cnt_r : en_cnt_r + 3'h1;
    if (!serial_config_enable_in) begin
      en_cnt_nxt = 3'h0;
    end
  end
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      en_cnt_r <= 3'h0;
    end else begin
      en_cnt_r <= en_cnt_nxt;
    end
  end
  assign en_ok = (en_cnt_r >= 3'h5);

  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);

  // --------------------------------------------------------------------------
  // Accepted accesses
  // --------------------------------------------------------------------------
  sequence s_wr(logic [7:0] a);
    en_ok && wr_strobe_in && !rd_strobe_in && reg_addr_in == a;
  endsequence
  sequence s_rd(logic [7:0] a);
    en_ok && rd_strobe_in && reg_addr_in == a;
  endsequence

  a_boost_write: assert property (s_wr(8'h0f) |=>
    b0_receive_boost_out == $past(wr_data_in[5:0])) else $error("boost write lost");
  a_swing_write: assert property (s_wr(8'h10) |=>
    b0_output_swing_out == $past(wr_data_in[5:0])) else $error("swing write lost");
  a_soft_default: assert property (s_wr(8'h00) ##0 wr_data_in[0] |=>
    b0_receive_boost_out == 6'h20 && b0_output_swing_out == 6'h03) else $error("no defaults");
  a_pd_lanes: assert property (s_wr(8'h01) |-> ##2
    (lane_power_down_out & $past(wr_data_in, 2)) == $past(wr_data_in, 2))
    else $error("lane not powered down");
  a_reset_reads0: assert property (s_rd(8'h00) |=> rd_data_out == 8'h00)
    else $error("reset bit reads set");
  a_rsvd_read0: assert property (en_ok && rd_strobe_in &&
    reg_addr_in inside {8'h0f, 8'h10} |=> rd_data_out[7:6] == 2'h0) else $error("reserved set");
  a_rd_hold: assert property (!rd_strobe_in |=> $stable(rd_data_out))
    else $error("read data moved");
  a_auto_excl: assert property (!(b0_lane_ctl_out.auto_idle &&
    b0_lane_ctl_out.output_mute) && !(b0_lane_ctl_out.auto_rate && b0_lane_ctl_out.rate_high))
    else $error("auto and forced both set");
endmodule

bind rcr_config_regs rcr_config_regs_chk u_chk (
  .ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .serial_config_enable_in(serial_config_enable_in),
  .wr_strobe_in(wr_strobe_in), .rd_strobe_in(rd_strobe_in), .reg_addr_in(reg_addr_in),
  .wr_data_in(wr_data_in), .rd_data_out(rd_data_out), .lane_power_down_out(lane_power_down_out),
  .b0_lane_ctl_out(b0_lane_ctl_out), .b0_receive_boost_out(b0_receive_boost_out),
  .b0_output_swing_out(b0_output_swing_out)
);

// file: dv/rcr_host_model.sv
// Byte-level model of the management-bus host that configures the bank.
// Assumes the bench calls xfer and the bank samples strobes on ref_clk_in.
`timescale 1ns/100ps
module rcr_host_model (
  input  wire logic       ref_clk_in,
  output logic            wr_strobe_out,
  output logic            rd_strobe_out,
  output logic      [7:0] reg_addr_out,
  output logic      [7:0] wr_data_out
);
  // Bus starts idle.
  initial begin
    wr_strobe_out = 1'b0;
    rd_strobe_out = 1'b0;
    reg_addr_out  = 8'h00;
    wr_data_out   = 8'h00;
  end

  // one register byte
  // Waits gap plus one cycles, strobes once, then scrambles the released bus lines.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, input int gap);
    repeat (gap) @(posedge ref_clk_in);
    @(posedge ref_clk_in);
    #1;
    wr_strobe_out = w;
    rd_strobe_out = !w;
    reg_addr_out  = a;
    wr_data_out   = d;
    @(posedge ref_clk_in);
    #1;
    wr_strobe_out = 1'b0;
    rd_strobe_out = 1'b0;
    reg_addr_out  = ~a;
    wr_data_out   = ~d;
  endtask
endmodule

// file: dv/tb.sv
// Self-checking bench for the repeater configuration bank.
// Assumes the host model drives the strobes and the checker is bound to the bank.
`timescale 1ns/100ps
module tb;
  typedef struct packed {logic [7:0] a; logic [7:0] v;} rcr_note_s;
  logic                   ref_clk_in, resetn_in, en, pd_pin, idle_pin, rate_pin, wr, rd;
  logic                   rd_seen = 1'b0;
  logic [7:0]             addr, wdata, rdata, lanes, d;
  logic [5:0]             swing;
  rcr_pkg::rcr_lane_ctl_s ctl;
  rcr_pkg::rcr_boost_s    boost;
  rcr_note_s              q[$];
  rcr_note_s              n;
  int                     failures = 0;
  int                     num_checks = 0;
  logic [7:0] ofs[8] = '{8'h00, 8'h01, 8'h02, 8'h08, 8'h0e, 8'h0f, 8'h10, 8'h05};
  logic [7:0] dflt[8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h20, 8'h03, 8'h00};
  logic [7:0] msk[8] = '{8'h00, 8'hff, 8'h01, 8'h14, 8'h33, 8'h3f, 8'h3f, 8'h00};
  logic [7:0] bcode[9] = '{8'h20, 8'h2a, 8'h30, 8'h31, 8'h38, 8'h34, 8'h35, 8'h3a, 8'h3c};
  logic [7:0] scode[5] = '{8'h03, 8'h07, 8'h0f, 8'h1f, 8'h3f};
  logic [7:0] iv[3] = '{8'h10, 8'h22, 8'h01};
  logic [3:0] ie[3] = '{4'h4, 4'ha, 4'h1};

  rcr_host_model u_host (.ref_clk_in(ref_clk_in), .wr_strobe_out(wr), .rd_strobe_out(rd),
    .reg_addr_out(addr), .wr_data_out(wdata));
  rcr_config_regs u_dut (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
    .serial_config_enable_in(en), .power_down_pin_in(pd_pin), .idle_pin_in(idle_pin),
    .rate_pin_in(rate_pin), .wr_strobe_in(wr), .rd_strobe_in(rd), .reg_addr_in(addr),
    .wr_data_in(wdata), .rd_data_out(rdata), .lane_power_down_out(lanes),
    .b0_lane_ctl_out(ctl), .b0_receive_boost_out(boost), .b0_output_swing_out(swing));

  // Counts a comparison and reports a mismatch.
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk_in);
    #1;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    u_host.xfer(1'b1, a, v, $urandom_range(2));
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] v);
    q.push_back({a, v});
    u_host.xfer(1'b0, a, 8'h00, $urandom_range(2));
  endtask
  task automatic report_and_stop();
    if (failures == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Clock and hang guard.
  initial begin
    ref_clk_in = 1'b0;
    forever #12.5 ref_clk_in = ~ref_clk_in;
  end
  initial begin
    repeat (5000) @(posedge ref_clk_in);
    failures++;
    report_and_stop();
  end

  // Compares each read result with the oldest note, one cycle after the strobe.
  always @(posedge ref_clk_in) begin
    if (rd_seen) begin
      n = q.pop_front();
      check("read data", n.v, rdata);
    end
    rd_seen <= rd;
  end

  // Main sequence: defaults, read-back, codes, lane controls, refusal.
  initial begin
    {resetn_in, pd_pin, idle_pin, rate_pin} = 4'h0;
    en = 1'b1;
    d = $urandom(43);
    tick(2);
    resetn_in = 1'b1;
    tick(6);
    foreach (ofs[i]) rd_reg(ofs[i], dflt[i]);
    for (int i = 1; i < 8; i++) begin
      d = $urandom;
      wr_reg(ofs[i], d);
      rd_reg(ofs[i], d & msk[i]);
    end
    wr_reg(8'h00, 8'h01);
    rd_reg(8'h00, 8'h00);
    for (int i = 1; i < 8; i++) rd_reg(ofs[i], dflt[i]);
    foreach (scode[i]) begin
      wr_reg(8'h10, scode[i]);
      check("swing", scode[i], {2'h0, swing});
    end
    foreach (bcode[i]) begin
      wr_reg(8'h0f, bcode[i]);
      check("boost", bcode[i], {2'h0, boost});
    end
    wr_reg(8'h01, 8'h81);
    tick(2);
    check("lanes", 8'h81, lanes);
    {pd_pin, idle_pin, rate_pin} = 3'h7;
    tick(6);
    check("lanes", 8'hff, lanes);
    check("lane ctl", 8'h09, {4'h0, ctl});
    wr_reg(8'h02, 8'h01);
    wr_reg(8'h08, 8'h14);
    foreach (iv[i]) begin
      wr_reg(8'h0e, iv[i]);
      tick(2);
      check("lane ctl", {4'h0, ie[i]}, {4'h0, ctl});
    end
    check("lanes", 8'h81, lanes);
    {pd_pin, idle_pin, rate_pin} = 3'h0;
    tick(6);
    check("lane ctl", 8'h01, {4'h0, ctl});
    wr_reg(8'h0e, 8'h00);
    tick(2);
    check("lane ctl", 8'h00, {4'h0, ctl});
    wr_reg(8'h08, 8'h00);
    idle_pin = 1'b1;
    tick(6);
    check("lane ctl", 8'h08, {4'h0, ctl});
    en = 1'b0;
    tick(6);
    wr_reg(8'h0f, 8'h3f);
    en = 1'b1;
    tick(6);
    rd_reg(8'h0f, 8'h3c);
    tick(3);
    report_and_stop();
  end
endmodule
